// File: hdl/iobd_defines.svh
// Offsets, field positions, codes and reset values of the I/O bus line decoder
`ifndef IOBD_DEFINES_SVH
`define IOBD_DEFINES_SVH
`define IOBD_OFS_CTRL 8'h00
`define IOBD_OFS_RING 8'h04
`define IOBD_OFS_LS 8'h08
`define IOBD_OFS_HP 8'h0C
`define IOBD_OFS_CHAIN 8'h10
`define IOBD_CTRL_RST 5'h00
`define IOBD_CTRL_PREV 0
`define IOBD_CTRL_NEXT 1
`define IOBD_CTRL_CSREQ 2
`define IOBD_CTRL_SELREQ 3
`define IOBD_CTRL_HPADP 4
`define IOBD_LS_BASE 7'h40
`define IOBD_HP_BASE 11'h404
`define IOBD_RING_BASE 11'h440
`define IOBD_RING_CONN 1'h0
`define IOBD_RING_TYPE 4'h9
`define IOBD_RING_GROUP 3'h0
`define IOBD_RING_CARD_HI 1'h0
`define IOBD_RDATA_RST 32'h0000_0000
`endif

// File: hdl/iobd_pkg.sv
// Types of the I/O bus line decoder
package iobd_pkg;
   typedef struct packed {
      logic hit;
      logic maint;
      logic module_sel;
      logic slot;
      logic card;
      logic [10:0] line;
   } iobd_ring_t;
   typedef struct packed {
      logic [6:0] line;
      logic rx;
      logic board;
      logic [2:0] pos;
      logic port;
   } iobd_ls_t;
   typedef struct packed {
      logic through;
      logic bypass;
      logic kept;
   } iobd_chain_t;
   typedef struct packed {
      logic ta1;
      logic ta2;
      logic ta3;
      logic td1;
      logic td2;
      logic td3;
      logic [15:0] bus1;
      logic [15:0] bus2;
      logic [3:0] ch1;
      logic [3:0] ch2;
   } iobd_sync_t;
   typedef struct packed {
      iobd_sync_t sy;
      logic [4:0] ctrl;
      logic hready;
      logic hresp;
      logic [31:0] hrdata;
      logic wr_pend;
      iobd_ring_t ring;
      iobd_ls_t ls;
      logic [10:0] hp_line;
      logic hp_valid;
      iobd_chain_t grant;
      iobd_chain_t samp;
   } iobd_state_t;
endpackage

// File: hdl/iobd_top.sv
// I/O bus line address decoder with chain bypass and AHB-Lite registers
// What this block does
// - Lines 64-95 map to byte values 2n/2n+1
// - Byte 1 bit 2 board, bits 3-5 position
// - Bit 6 coupler port, bit 7 receive flag
// - Two fast lines addressable, one active
// - Byte 1 bit 6 picks fast port
// - Fast lines 1028 to 1031 by adapter
// - Ring selection decoded at address phase
// - Byte 0 bit 0 is bus connection
// - Respond only to type code 1001
// - Group address must be 000
// - Byte 1 bit 4 gives command originator
// - Bit 5 routes to card or module
// - Bit 6 selects module slot 1 or 2
// - Bits 2-3 pick interface card 1 or 2
// - Interface cards take lines 1088 to 1091
// - Hold neighbour presence to steer bypass
// - Bypass acts on grant and select chains
// - Line adapters have no bypass path
// - Requesting adapter keeps grant, others forward
//
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "iobd_defines.svh"
module iobd_top (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic io_addr_phase,
   input wire logic io_data_phase,
   input wire logic [15:0] io_bus,
   input wire logic grant_through_in,
   input wire logic grant_bypass_in,
   input wire logic sample_in,
   input wire logic sample_bypass_in,
   output logic grant_through_out,
   output logic grant_bypass_out,
   output logic grant_kept,
   output logic sample_out,
   output logic sample_bypass_out,
   output logic sample_kept,
   output iobd_pkg::iobd_ring_t ring_sel,
   output iobd_pkg::iobd_ls_t ls_sel,
   output logic [10:0] hp_line,
   output logic hp_valid
);
   iobd_pkg::iobd_state_t st_r;
   iobd_pkg::iobd_state_t st_nxt;
   logic ta_edge;
   logic td_edge;
   logic ahb_go;
   logic [7:0] ofs;

   // One chain stage; used for both the grant and the select chain
   function automatic iobd_pkg::iobd_chain_t chain_step(
      input logic thr_in,
      input logic byp_in,
      input logic prev,
      input logic next,
      input logic keep
   );
      iobd_pkg::iobd_chain_t c;
      logic sel;
      sel = prev ? thr_in : byp_in;
      c.kept = sel & keep;
      c.through = sel & ~keep & next;
      c.bypass = sel & ~keep & ~next;
      return c;
   endfunction

   assign ta_edge = st_r.sy.ta2 & ~st_r.sy.ta3;
   assign td_edge = st_r.sy.td2 & ~st_r.sy.td3;
   assign ahb_go = hsel & hready & htrans[1];
   assign ofs = haddr[7:0];

   always_comb begin
      st_nxt = st_r;
      // Pins cross in through two flops; the bus is sampled with its strobe
      st_nxt.sy.ta1 = io_addr_phase;
      st_nxt.sy.ta2 = st_r.sy.ta1;
      st_nxt.sy.ta3 = st_r.sy.ta2;
      st_nxt.sy.td1 = io_data_phase;
      st_nxt.sy.td2 = st_r.sy.td1;
      st_nxt.sy.td3 = st_r.sy.td2;
      st_nxt.sy.bus1 = io_bus;
      st_nxt.sy.bus2 = st_r.sy.bus1;
      st_nxt.sy.ch1 = {grant_through_in, grant_bypass_in, sample_in, sample_bypass_in};
      st_nxt.sy.ch2 = st_r.sy.ch1;

      // Register bus: zero wait, always OKAY
      st_nxt.hready = 1'b1;
      st_nxt.hresp = 1'b0;
      st_nxt.wr_pend = ahb_go & hwrite & (ofs == `IOBD_OFS_CTRL);
      if (st_r.wr_pend) begin
         st_nxt.ctrl = hwdata[4:0];
      end
      if (ahb_go & ~hwrite) begin
         unique case (ofs)
            `IOBD_OFS_CTRL: st_nxt.hrdata = {27'h0000000, st_r.ctrl};
            `IOBD_OFS_RING: st_nxt.hrdata = {5'h00, st_r.ring.line, 11'h000, st_r.ring.card,
                                           st_r.ring.slot, st_r.ring.module_sel,
                                           st_r.ring.maint, st_r.ring.hit};
            `IOBD_OFS_LS: st_nxt.hrdata = {18'h00000, st_r.ls.port, st_r.ls.pos,
                                         st_r.ls.board, st_r.ls.rx, 1'b0, st_r.ls.line};
            `IOBD_OFS_HP: st_nxt.hrdata = {15'h0000, st_r.hp_valid, 5'h00, st_r.hp_line};
            `IOBD_OFS_CHAIN: st_nxt.hrdata = {30'h00000000, st_r.samp.kept, st_r.grant.kept};
            default: st_nxt.hrdata = `IOBD_RDATA_RST;
         endcase
      end

      // Ring selection is taken from the address-phase halfword only
      if (ta_edge) begin
         // Mismatch drops the hit so nothing answers for a foreign adapter
         st_nxt.ring.hit = (st_r.sy.bus2[15] == `IOBD_RING_CONN)
                         & (st_r.sy.bus2[14:11] == `IOBD_RING_TYPE)
                         & (st_r.sy.bus2[10:8] == `IOBD_RING_GROUP)
                         & (st_r.sy.bus2[5] == `IOBD_RING_CARD_HI);
         st_nxt.ring.maint = st_r.sy.bus2[3];
         st_nxt.ring.module_sel = st_r.sy.bus2[2];
         st_nxt.ring.slot = st_r.sy.bus2[1];
         st_nxt.ring.card = st_r.sy.bus2[4];
         st_nxt.ring.line = `IOBD_RING_BASE + {9'h000, st_r.sy.bus2[1], st_r.sy.bus2[4]};
      end

      // Data phase byte 1 carries coupler and port selection
      if (td_edge) begin
         st_nxt.ls.line = `IOBD_LS_BASE + {2'h0, st_r.sy.bus2[5:1]};
         st_nxt.ls.board = st_r.sy.bus2[5];
         st_nxt.ls.pos = st_r.sy.bus2[4:2];
         st_nxt.ls.port = st_r.sy.bus2[1];
         st_nxt.ls.rx = st_r.sy.bus2[0];
         // A new port replaces the old one, so one fast line is live at a time
         st_nxt.hp_line = `IOBD_HP_BASE
                        + {9'h000, st_r.ctrl[`IOBD_CTRL_HPADP], st_r.sy.bus2[1]};
         st_nxt.hp_valid = 1'b1;
      end

      // Bypass only steers the channel-adapter chains; the line-adapter
      // chain relies on pass-through cards and has no such path
      st_nxt.grant = chain_step(st_r.sy.ch2[3], st_r.sy.ch2[2], st_r.ctrl[`IOBD_CTRL_PREV],
                                st_r.ctrl[`IOBD_CTRL_NEXT], st_r.ctrl[`IOBD_CTRL_CSREQ]);
      st_nxt.samp = chain_step(st_r.sy.ch2[1], st_r.sy.ch2[0], st_r.ctrl[`IOBD_CTRL_PREV],
                               st_r.ctrl[`IOBD_CTRL_NEXT], st_r.ctrl[`IOBD_CTRL_SELREQ]);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.hready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.hready;
   assign hrdata = st_r.hrdata;
   assign hresp = st_r.hresp;
   assign grant_through_out = st_r.grant.through;
   assign grant_bypass_out = st_r.grant.bypass;
   assign grant_kept = st_r.grant.kept;
   assign sample_out = st_r.samp.through;
   assign sample_bypass_out = st_r.samp.bypass;
   assign sample_kept = st_r.samp.kept;
   assign ring_sel = st_r.ring;
   assign ls_sel = st_r.ls;
   assign hp_line = st_r.hp_line;
   assign hp_valid = st_r.hp_valid;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // Low-speed coupler view, updated on the data phase only
   ls_line_map_a: assert property (td_edge |=>
      ls_sel.line == `IOBD_LS_BASE + {2'h0, $past(st_r.sy.bus2[5:1])})
      else $error("low-speed line number wrong");
   ls_range_a: assert property (td_edge |=>
      ls_sel.line >= `IOBD_LS_BASE && ls_sel.line <= `IOBD_LS_BASE + 7'h1F)
      else $error("low-speed line out of range");
   ls_board_pos_a: assert property (td_edge |=>
      ls_sel.board == $past(st_r.sy.bus2[5]) && ls_sel.pos == $past(st_r.sy.bus2[4:2]))
      else $error("board or position wrong");
   ls_port_rx_a: assert property (td_edge |=>
      ls_sel.port == $past(st_r.sy.bus2[1]) && ls_sel.rx == $past(st_r.sy.bus2[0]))
      else $error("port or direction wrong");
   ls_hold_a: assert property (!td_edge |=>
      $stable(ls_sel))
      else $error("low-speed view moved without data phase");

   // Fast scanner: each data phase replaces the live line
   hp_port_a: assert property (td_edge |=>
      hp_valid && hp_line[0] == $past(st_r.sy.bus2[1]))
      else $error("fast port wrong");
   hp_range_a: assert property (hp_valid |->
      hp_line >= `IOBD_HP_BASE && hp_line <= `IOBD_HP_BASE + 11'h003)
      else $error("fast line out of range");
   hp_adapter_a: assert property (td_edge |=>
      hp_line[1] == $past(st_r.ctrl[`IOBD_CTRL_HPADP]))
      else $error("fast adapter pair wrong");
   hp_hold_a: assert property (!td_edge |=>
      $stable(hp_line) && $stable(hp_valid))
      else $error("fast line moved without data phase");
   hp_sticky_a: assert property (hp_valid |=>
      hp_valid)
      else $error("fast line dropped");

   // Ring selection, taken from the address phase only
   ring_type_a: assert property (ta_edge && st_r.sy.bus2[14:11] != `IOBD_RING_TYPE |=>
      !ring_sel.hit)
      else $error("foreign type selected");
   ring_group_a: assert property (ta_edge && st_r.sy.bus2[10:8] != `IOBD_RING_GROUP |=>
      !ring_sel.hit)
      else $error("foreign group selected");
   ring_conn_a: assert property (ta_edge && st_r.sy.bus2[15] != `IOBD_RING_CONN |=>
      !ring_sel.hit)
      else $error("connection bit ignored");
   ring_card_a: assert property (ta_edge && st_r.sy.bus2[5] != `IOBD_RING_CARD_HI |=>
      !ring_sel.hit)
      else $error("card code out of range selected");
   ring_match_a: assert property (ta_edge && st_r.sy.bus2[5] == `IOBD_RING_CARD_HI &&
      st_r.sy.bus2[15:8] == {`IOBD_RING_CONN, `IOBD_RING_TYPE, `IOBD_RING_GROUP} |=> ring_sel.hit)
      else $error("matching address not selected");
   ring_route_a: assert property (ta_edge |=>
      ring_sel.module_sel == $past(st_r.sy.bus2[2]) && ring_sel.maint == $past(st_r.sy.bus2[3]))
      else $error("ring routing wrong");
   ring_slot_a: assert property (ta_edge |=>
      ring_sel.slot == $past(st_r.sy.bus2[1]))
      else $error("module slot wrong");
   ring_tic_a: assert property (ta_edge |=>
      ring_sel.card == $past(st_r.sy.bus2[4]))
      else $error("interface card wrong");
   ring_line_a: assert property (ring_sel.hit |->
      ring_sel.line == `IOBD_RING_BASE + {9'h000, ring_sel.slot, ring_sel.card})
      else $error("ring line wrong");
   ring_range_a: assert property (ring_sel.hit |->
      ring_sel.line >= `IOBD_RING_BASE && ring_sel.line <= `IOBD_RING_BASE + 11'h003)
      else $error("ring line out of range");
   ring_hold_a: assert property (!ta_edge |=>
      $stable(ring_sel))
      else $error("ring selection moved without address phase");

   // Chains: outputs follow the neighbour flags of the previous cycle
   grant_keep_a: assert property (grant_kept |->
      !grant_through_out && !grant_bypass_out)
      else $error("kept grant passed on");
   grant_kept_a: assert property (grant_kept |->
      $past(st_r.ctrl[`IOBD_CTRL_CSREQ]))
      else $error("grant kept without request");
   grant_through_a: assert property (grant_through_out |->
      $past(st_r.ctrl[`IOBD_CTRL_NEXT]) && !$past(st_r.ctrl[`IOBD_CTRL_CSREQ]))
      else $error("grant forwarded wrongly");
   grant_bypass_a: assert property (grant_bypass_out |->
      !$past(st_r.ctrl[`IOBD_CTRL_NEXT]))
      else $error("bypass with next present");
   grant_source_a: assert property (grant_kept || grant_through_out || grant_bypass_out |->
      ($past(st_r.ctrl[`IOBD_CTRL_PREV]) ? $past(st_r.sy.ch2[3]) : $past(st_r.sy.ch2[2])))
      else $error("grant taken from wrong input");
   grant_pass_a: assert property (st_r.sy.ch2[3] && st_r.ctrl[`IOBD_CTRL_PREV] &&
      st_r.ctrl[`IOBD_CTRL_NEXT] && !st_r.ctrl[`IOBD_CTRL_CSREQ] |=> grant_through_out)
      else $error("grant not forwarded");
   grant_skip_a: assert property (st_r.sy.ch2[2] && !st_r.ctrl[`IOBD_CTRL_PREV] &&
      !st_r.ctrl[`IOBD_CTRL_NEXT] && !st_r.ctrl[`IOBD_CTRL_CSREQ] |=> grant_bypass_out)
      else $error("grant not bypassed");
   sample_pass_a: assert property ($rose(st_r.sy.ch2[1]) && st_r.ctrl[`IOBD_CTRL_PREV] &&
      st_r.ctrl[`IOBD_CTRL_NEXT] && !st_r.ctrl[`IOBD_CTRL_SELREQ] |=> sample_out)
      else $error("select not forwarded");
   sample_keep_a: assert property (sample_kept |->
      !sample_out && !sample_bypass_out && $past(st_r.ctrl[`IOBD_CTRL_SELREQ]))
      else $error("kept select passed on");
   sample_bypass_a: assert property (sample_bypass_out |->
      !$past(st_r.ctrl[`IOBD_CTRL_NEXT]))
      else $error("select bypass with next present");

   // Register bus
   ahb_okay_a: assert property (
      hreadyout && !hresp)
      else $error("bus answer not OKAY");
   ctrl_write_a: assert property (st_r.wr_pend |=>
      st_r.ctrl == $past(hwdata[4:0]))
      else $error("neighbour flags not stored");
   ctrl_hold_a: assert property (!st_r.wr_pend |=>
      $stable(st_r.ctrl))
      else $error("neighbour flags changed without write");
   rd_ctrl_a: assert property (ahb_go && !hwrite && ofs == `IOBD_OFS_CTRL |=>
      hrdata == {27'h0000000, $past(st_r.ctrl)})
      else $error("control read wrong");
   rd_ring_a: assert property (ahb_go && !hwrite && ofs == `IOBD_OFS_RING |=>
      hrdata[26:16] == $past(ring_sel.line) && hrdata[0] == $past(ring_sel.hit))
      else $error("ring read wrong");
   rd_hp_a: assert property (ahb_go && !hwrite && ofs == `IOBD_OFS_HP |=>
      hrdata[16] == $past(hp_valid) && hrdata[10:0] == $past(hp_line))
      else $error("fast line read wrong");
   rd_chain_a: assert property (ahb_go && !hwrite && ofs == `IOBD_OFS_CHAIN |=>
      hrdata[1:0] == $past({sample_kept, grant_kept}))
      else $error("chain read wrong");

   ring_hit_c: cover property (ta_edge ##1 ring_sel.hit);
   hp_live_c: cover property (td_edge ##1 hp_valid);
   grant_kept_c: cover property (grant_kept);
   samp_byp_c: cover property (sample_bypass_out);
   samp_kept_c: cover property (sample_kept);
endmodule

// File: verif/iobd_ccu_model.sv
// Central control unit model issuing I/O halfword commands
`timescale 1ns/1ps
module iobd_ccu_model (
   input wire logic sys_clk,
   output logic io_addr_phase,
   output logic io_data_phase,
   output logic [15:0] io_bus
);
   initial begin
      io_addr_phase = 1'b0;
      io_data_phase = 1'b0;
      io_bus = 16'hFFFF;
   end
   // Halfword held 3 clocks before and 3 clocks after the strobe edge, then inverted so stale data never matches
   task automatic phase(input logic ta, input logic [15:0] hw);
      begin
         io_bus <= hw;
         repeat (3) @(posedge sys_clk);
         if (ta) io_addr_phase <= 1'b1;
         else io_data_phase <= 1'b1;
         repeat (3) @(posedge sys_clk);
         io_addr_phase <= 1'b0;
         io_data_phase <= 1'b0;
         io_bus <= ~hw;
         repeat (3) @(posedge sys_clk);
      end
   endtask
   task automatic send(input logic [15:0] ta, input logic [15:0] td);
      begin
         phase(1'b1, ta);
         phase(1'b0, td);
      end
   endtask
endmodule

// File: verif/iobd_top_bench.sv
// Self-checking bench of the I/O bus line decoder
`timescale 1ns/1ps
module iobd_top_bench;
   logic sys_clk, nrst, hsel, hwrite, hready, hreadyout, hresp, hp_valid, io_a, io_d;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [10:0] hp_line;
   logic [15:0] io_bus;
   logic [3:0] ch;
   logic [5:0] co;
   logic [4:0] ctl;
   logic [7:0] b0, b1;
   logic [5:0] td6;
   iobd_pkg::iobd_ring_t ring_sel;
   iobd_pkg::iobd_ls_t ls_sel;
   integer err_total = 0, total_checks = 0, seed = 32'h72841D78, i;
   assign hready = hreadyout;
   iobd_ccu_model i_iobd_ccu_model (.sys_clk(sys_clk), .io_addr_phase(io_a), .io_data_phase(io_d), .io_bus(io_bus));
   iobd_top i_iobd_top (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .io_addr_phase(io_a), .io_data_phase(io_d), .io_bus(io_bus),
      .grant_through_in(ch[3]), .grant_bypass_in(ch[2]), .sample_in(ch[1]), .sample_bypass_in(ch[0]),
      .grant_through_out(co[4]), .grant_bypass_out(co[3]), .grant_kept(co[5]), .sample_out(co[1]),
      .sample_bypass_out(co[0]), .sample_kept(co[2]), .ring_sel(ring_sel), .ls_sel(ls_sel),
      .hp_line(hp_line), .hp_valid(hp_valid));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_total);
         if (err_total == 0 && total_checks > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks++;
         if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Waits for hready under a bound; a stuck slave ends the run
   task automatic wt;
      integer n;
      begin
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (hready !== 1'b1 && n < 50);
         if (hready !== 1'b1) begin
            err_total++;
            conclude;
         end
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= a;
         hwrite <= w;
         wt;
         hsel <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
         wt;
         r = hrdata;
         chk({30'h0, hready, hresp}, 32'h2);
      end
   endtask
   function automatic logic [15:0] ring_exp(input logic [7:0] a0, input logic [7:0] a1);
      iobd_pkg::iobd_ring_t e;
      begin
         e.hit = (a0 === 8'h48) && !a1[5];
         e.maint = a1[3];
         e.module_sel = a1[2];
         e.slot = a1[1];
         e.card = a1[4];
         e.line = 11'h440 + {9'h0, a1[1], a1[4]};
         return e;
      end
   endfunction
   function automatic logic [12:0] ls_exp(input logic [5:0] t);
      return {7'h40 + {2'h0, t[5:1]}, t[0], t[5], t[4:2], t[1]};
   endfunction
   // Returns kept, through and bypass of one chain
   function automatic logic [2:0] link(input logic thr, input logic byp, input logic [4:0] c, input logic req);
      logic x;
      begin
         x = c[0] ? thr : byp;
         return {req & x, !req & c[1] & x, !req & !c[1] & x};
      end
   endfunction
   initial begin
      nrst = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ch = 4'h0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      // Reset values read at all six offsets, then all-ones written to each; only control is read back
      for (i = 0; i < 6; i++) begin
         ahb(1'b0, 32'(4 * i), 32'h0, rd);
         chk(rd, 32'h0);
         ahb(1'b1, 32'(4 * i), 32'hFFFF_FFFF, rd);
      end
      ahb(1'b0, 32'h0, 32'h0, rd);
      chk(rd, 32'h1F);
      for (i = 0; i < 40; i++) begin
         ctl = 5'($random(seed));
         ch <= 4'($random(seed));
         ahb(1'b1, 32'h0, {27'h0, ctl}, rd);
         // Odd passes match in byte 0; even passes flip one address-phase bit each
         b0 = i[0] ? 8'h48 : 8'h48 ^ (8'h01 << i[3:1]);
         b1 = 8'($random(seed));
         td6 = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($random(seed));
         i_iobd_ccu_model.send({b0, b1}, {10'h0, td6});
         repeat (3) @(posedge sys_clk);
         chk(32'(ring_sel), 32'(ring_exp(b0, b1)));
         chk(32'(ls_sel), 32'(ls_exp(td6)));
         chk({20'h0, hp_valid, hp_line}, {20'h0, 1'b1, 11'h404 + {9'h0, ctl[4], td6[1]}});
         chk({26'h0, co}, {26'h0, link(ch[3], ch[2], ctl, ctl[2]), link(ch[1], ch[0], ctl, ctl[3])});
      end
      conclude;
   end
endmodule
